// File: bench/host_reader.sv
/*
 Host-side reader of the monitor transistors: latches what the host
 equipment would see on each clock.
 Assumes the transistor outputs are registered on hclk by the device.
*/
`timescale 1ns/1ns
module host_reader (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [21:0] lines,
    output logic [21:0] seen
);
    // Host polls once a cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen <= 22'h000000;
        end else begin
            seen <= lines;
        end
    end
endmodule : host_reader

// File: bench/monitor_sel_chk.sv
/*
 Checker for the monitor selector: output 0 against a bus-snooped copy
 of its source code, its polarity bit and the control bits.
 Assumes one AHB-Lite master with IDLE cycles between transfers.
*/
`timescale 1ns/1ns
module monitor_sel_chk (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic zone_permit,
    input wire logic burner_permit,
    input wire logic pilot_check_done,
    input wire logic high_fire,
    input wire logic damper_modulating,
    input wire logic diag_one_active,
    input wire logic starting_up,
    input wire logic setup_mode,
    input wire logic [21:0] transistor_conducting
);
    logic wr_pend_r;
    logic [7:0] wa_r;
    logic [4:0] ctrl_r;
    logic pol_r;
    logic [5:0] code_r;
    wire take = hsel & hready & htrans[1];
    wire out0 = transistor_conducting[0];
    wire perm = ctrl_r[4] ? burner_permit : zone_permit;
    wire exp_perm = perm ^ pol_r;
    wire exp_pchk = pilot_check_done ^ pol_r;
    wire exp_fire = (ctrl_r[3] & high_fire & ~damper_modulating) ^ pol_r;
    wire exp_run = (starting_up & ~setup_mode) ^ pol_r;
    // Shadow updates in the data phase, same edge as the real register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wa_r <= 8'h00;
            ctrl_r <= 5'h00;
            pol_r <= 1'b0;
            code_r <= 6'h00;
        end else begin
            wr_pend_r <= take & hwrite;
            wa_r <= haddr[7:0];
            if (wr_pend_r && wa_r == monitor_pkg::OFS_CTRL) ctrl_r <= hwdata[4:0];
            if (wr_pend_r && wa_r == monitor_pkg::OFS_POLARITY) pol_r <= hwdata[0];
            if (wr_pend_r && wa_r == monitor_pkg::OFS_SELECT0) code_r <= hwdata[5:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // =========================================================
    // Bus and output properties
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    unmapped_zero_a: assert property (take && !hwrite && haddr[7:0] == 8'h40
        |=> hrdata == 32'h0) else $error("unmapped read not zero");
    reset_off_a: assert property ($rose(hresetn) |-> transistor_conducting == 22'h0)
        else $error("outputs on after reset");
    unused_off_a: assert property (code_r == 6'h00 |=> !out0)
        else $error("unused output conducting");
    permit_src_a: assert property (code_r == 6'h01 |=> out0 == $past(exp_perm))
        else $error("permit output wrong");
    pilot_chk_a: assert property (code_r == 6'h03 |=> out0 == $past(exp_pchk))
        else $error("pilot check output wrong");
    fire_pos_a: assert property (code_r == 6'h06 |=> out0 == $past(exp_fire))
        else $error("fire position output wrong");
    run_src_a: assert property (code_r == 6'h0A |=> out0 == $past(exp_run))
        else $error("run output wrong");
    diag_direct_a: assert property (code_r == 6'h08
        |=> out0 == $past(diag_one_active))
        else $error("diagnosis output not direct");
endmodule : monitor_sel_chk
bind monitor_output_select_polarity monitor_sel_chk u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .zone_permit(zone_permit), .burner_permit(burner_permit),
    .pilot_check_done(pilot_check_done), .high_fire(high_fire),
    .damper_modulating(damper_modulating), .diag_one_active(diag_one_active),
    .starting_up(starting_up), .setup_mode(setup_mode),
    .transistor_conducting(transistor_conducting));

// File: bench/test_monitor_output_select_polarity.sv
/*
 Self-checking bench for the monitor selector: table of source cases on
 output 0, then input monitors, first-out lockout and flicker.
 Assumes the selector answers with zero wait states; tick shortened.
*/
`timescale 1ns/1ns
module test_monitor_output_select_polarity;
    typedef struct packed {
        logic [5:0] code;
        logic [4:0] ctrl;
        logic pol;
        logic [11:0] st;
        logic exp;
    } row_t;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] field_in = 16'h0;
    logic lockout = 1'b0;
    logic [11:0] st = 12'h000;
    logic [31:0] rd;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire [21:0] tc;
    wire [21:0] seen;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int ones;
    // Status bits: zone burner poff pchk relay blower high damp d1 d2 run setup
    row_t rows [16] = '{
        '{6'h00, 5'h00, 1'b1, 12'hFFF, 1'b0}, '{6'h01, 5'h00, 1'b0, 12'h800, 1'b1},
        '{6'h01, 5'h10, 1'b0, 12'h800, 1'b0}, '{6'h01, 5'h10, 1'b1, 12'h400, 1'b0},
        '{6'h02, 5'h00, 1'b0, 12'h200, 1'b1}, '{6'h03, 5'h00, 1'b1, 12'h000, 1'b1},
        '{6'h04, 5'h02, 1'b0, 12'h080, 1'b1}, '{6'h05, 5'h04, 1'b0, 12'h040, 1'b1},
        '{6'h06, 5'h08, 1'b0, 12'h020, 1'b1}, '{6'h06, 5'h08, 1'b0, 12'h030, 1'b0},
        '{6'h07, 5'h08, 1'b0, 12'h010, 1'b1}, '{6'h08, 5'h00, 1'b1, 12'h008, 1'b1},
        '{6'h09, 5'h00, 1'b1, 12'h000, 1'b0}, '{6'h0A, 5'h00, 1'b0, 12'h002, 1'b1},
        '{6'h0A, 5'h00, 1'b0, 12'h003, 1'b0}, '{6'h04, 5'h00, 1'b0, 12'h080, 1'b0}};
    // Short tick keeps delays and flicker brief
    monitor_output_select_polarity #(.TICK_CYCLES(24'h00000A)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .field_in(field_in), .lockout(lockout),
        .zone_permit(st[11]), .burner_permit(st[10]),
        .pilot_off_done(st[9]), .pilot_check_done(st[8]),
        .relay_on(st[7]), .blower_on(st[6]), .high_fire(st[5]),
        .damper_modulating(st[4]), .diag_one_active(st[3]),
        .diag_two_active(st[2]), .starting_up(st[1]), .setup_mode(st[0]),
        .transistor_conducting(tc));
    host_reader host (.hclk(hclk), .hresetn(hresetn), .lines(tc), .seen(seen));
    // =========================================================
    // Clock, timeout and reporting
    initial forever #10 hclk = ~hclk;
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    task check(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Single word transfer; request held until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // =========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, monitor_pkg::OFS_POLARITY, 32'h0);
        check("polarity reset", rd, 32'h0);
        bus(1'b0, monitor_pkg::OFS_SELECT0, 32'h0);
        check("select reset", rd, 32'h0);
        check("outputs reset", {10'h0, tc}, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped read", rd, 32'h0);
        for (int i = 0; i < 16; i++) begin
            st <= rows[i].st;
            bus(1'b1, monitor_pkg::OFS_CTRL, {27'h0, rows[i].ctrl});
            bus(1'b1, monitor_pkg::OFS_POLARITY, {31'h0, rows[i].pol});
            bus(1'b1, monitor_pkg::OFS_SELECT0, {26'h0, rows[i].code});
            repeat (2) @(posedge hclk);
            check("row output", {31'h0, tc[0]}, {31'h0, rows[i].exp});
        end
        // Raw, delayed and first-out views of input 1, off-delay 3 ticks
        bus(1'b1, monitor_pkg::OFS_DELAY0, 32'h3);
        bus(1'b1, monitor_pkg::OFS_SELECT0, 32'h00103020);
        field_in <= 16'h0001;
        repeat (10) @(posedge hclk);
        check("input on", {29'h0, tc[2:0]}, 32'h3);
        field_in <= 16'h0000;
        repeat (8) @(posedge hclk);
        check("in off-delay", {29'h0, tc[2:0]}, 32'h2);
        bus(1'b0, monitor_pkg::OFS_IN_STATE, 32'h0);
        check("in state", rd, 32'h00010000);
        repeat (40) @(posedge hclk);
        check("delay over", {29'h0, tc[2:0]}, 32'h4);
        // Lockout: inputs 2 and 3 eligible, input 1 off but not eligible
        bus(1'b1, monitor_pkg::OFS_ELIGIBLE, 32'h6);
        bus(1'b1, monitor_pkg::OFS_SELECT0, 32'h00121110);
        lockout <= 1'b1;
        repeat (4) @(posedge hclk);
        check("lockout view", {29'h0, tc[2:0]}, 32'h2);
        bus(1'b0, monitor_pkg::OFS_FIRST_OUT, 32'h0);
        check("first out", rd, 32'h2);
        check("host view", {10'h0, seen}, {10'h0, tc});
        // Flicker: half period 50 cycles, so about half of 200 are on
        bus(1'b1, monitor_pkg::OFS_CTRL, 32'h1);
        ones = 0;
        repeat (200) begin
            @(posedge hclk);
            ones += int'(tc[1]);
        end
        check("blinking", {31'h0, ones > 60 && ones < 140}, 32'h1);
        give_verdict();
    end
endmodule : test_monitor_output_select_polarity

// File: src/input_conditioner.sv
/*
 One field input: three-stage synchroniser, agreement filter and a
 retriggerable off-delay counted in time-base ticks.
 Assumes tick is a one-cycle pulse on hclk.
*/
`timescale 1ns/1ns
module input_conditioner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pin,
    input wire logic tick,
    input wire logic [7:0] delay_ticks,
    output logic raw_state,
    output logic delayed_state
);
    // ==============================================================
    // Synchroniser
    logic s1_r, s2_r, s3_r;
    logic stable_r;
    logic held_r;
    logic [7:0] cnt_r;

    // First stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
        end else begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_r <= 1'b0;
        end else if (s2_r == s3_r) begin
            stable_r <= s2_r;
        end
    end

    // ==============================================================
    // Off-delay: hold on until the delay has run out after release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            held_r <= 1'b0;
            cnt_r <= 8'h00;
        end else if (stable_r) begin
            held_r <= 1'b1;
            cnt_r <= delay_ticks;
        end else if (cnt_r == 8'h00) begin
            held_r <= 1'b0;
        end else if (tick) begin
            cnt_r <= cnt_r - 8'h01;
        end
    end

    assign raw_state = stable_r;
    assign delayed_state = held_r;
endmodule : input_conditioner

// File: src/monitor_cell.sv
/*
 Source selection and polarity for one monitor output, combinational.
 Assumes the caller registers the result before it leaves the block.
*/
`timescale 1ns/1ns
module monitor_cell (
    input wire logic [5:0] code,
    input wire logic reverse,
    input wire logic [15:0] first_vec,
    input wire logic [15:0] raw_vec,
    input wire logic [15:0] delayed_vec,
    input wire logic [10:0] single_vec,
    output logic drive
);
    // ==============================================================
    // Decode
    wire [1:0] grp = code[5:4];
    wire [3:0] idx = code[3:0];
    wire is_single = (grp == monitor_pkg::GRP_SINGLE);
    // Indices past the last source behave as unused, never as garbage
    wire idx_bad = (idx > monitor_pkg::SRC_RUN);
    wire is_unused = is_single &&
        ((idx == monitor_pkg::SRC_UNUSED) || idx_bad);
    wire is_diag = is_single &&
        ((idx == monitor_pkg::SRC_DIAG_ONE) ||
         (idx == monitor_pkg::SRC_DIAG_TWO));
    wire single_bit = idx_bad ? 1'b0 : single_vec[idx];

    // Direct-logic value of the chosen source
    wire direct =
        (grp == monitor_pkg::GRP_FIRST) ? first_vec[idx] :
        (grp == monitor_pkg::GRP_RAW) ? raw_vec[idx] :
        (grp == monitor_pkg::GRP_DELAYED) ? delayed_vec[idx] :
        single_bit;

    // Unused forces off; diagnosis ignores polarity
    assign drive = is_unused ? 1'b0 :
        is_diag ? direct :
        (direct ^ reverse);
endmodule : monitor_cell

// File: src/monitor_output_select_polarity.sv
/*
 Monitor output selector: 16 field inputs conditioned, first-out
 capture, flicker time base, 22 selectable outputs with polarity, and an
 AHB-Lite slave for configuration and status.
 Assumes status inputs come from logic on hclk, field inputs from pins.
*/
`timescale 1ns/1ns
module monitor_output_select_polarity #(
    parameter logic [23:0] TICK_CYCLES = monitor_pkg::TICK_CYCLES,
    parameter logic [3:0] FLICKER_TICKS = monitor_pkg::FLICKER_TICKS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [15:0] field_in,
    input wire logic lockout,
    input wire logic zone_permit,
    input wire logic burner_permit,
    input wire logic pilot_off_done,
    input wire logic pilot_check_done,
    input wire logic relay_on,
    input wire logic blower_on,
    input wire logic high_fire,
    input wire logic damper_modulating,
    input wire logic diag_one_active,
    input wire logic diag_two_active,
    input wire logic starting_up,
    input wire logic setup_mode,
    output logic [21:0] transistor_conducting
);
    localparam int NI = monitor_pkg::N_IN;
    localparam int NO = monitor_pkg::N_OUT;

    // ==============================================================
    // Configuration registers
    logic [monitor_pkg::CTRL_W-1:0] ctrl_r;
    logic [NO-1:0] polarity_r;
    logic [NI-1:0] eligible_r;
    logic [7:0] delay_r [NI];
    logic [5:0] select_r [NO];

    // Bus pipeline and outputs
    logic wr_pend_r;
    logic [5:0] wr_idx_r;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic [NO-1:0] out_r;

    // Time base and first-out state
    logic [23:0] tick_cnt_r;
    logic tick_r;
    logic [3:0] flick_cnt_r;
    logic blink_r;
    logic [NI-1:0] first_r;

    // Conditioned inputs and per-output drives
    logic [NI-1:0] raw_state;
    logic [NI-1:0] delayed_state;
    logic [NO-1:0] drive;

    // ==============================================================
    // Bus decode: zero wait states, so hready is always our own
    wire addr_phase = hsel && hready && htrans[1];
    wire [5:0] a_idx = haddr[7:2];
    wire hi_zero = (haddr[31:8] == 24'h000000);
    wire rd_take = addr_phase && !hwrite;
    wire wr_take = addr_phase && hwrite && hi_zero;
    wire [5:0] ctrl_i = monitor_pkg::OFS_CTRL[7:2];
    wire [5:0] pol_i = monitor_pkg::OFS_POLARITY[7:2];
    wire [5:0] elig_i = monitor_pkg::OFS_ELIGIBLE[7:2];
    wire [5:0] dly_i = monitor_pkg::OFS_DELAY0[7:2];
    wire [5:0] sel_i = monitor_pkg::OFS_SELECT0[7:2];
    wire [5:0] ost_i = monitor_pkg::OFS_OUT_STATE[7:2];
    wire [5:0] ist_i = monitor_pkg::OFS_IN_STATE[7:2];
    wire [5:0] fo_i = monitor_pkg::OFS_FIRST_OUT[7:2];
    wire [5:0] rd_dly = a_idx - dly_i;
    wire [5:0] rd_sel = a_idx - sel_i;
    wire rd_is_dly = (a_idx >= dly_i) &&
        (rd_dly < 6'(monitor_pkg::N_DELAY_REGS));
    wire rd_is_sel = (a_idx >= sel_i) &&
        (rd_sel < 6'(monitor_pkg::N_SELECT_REGS));

    // Packed views of the arrays, four fields to a word
    logic [31:0] dly_word [monitor_pkg::N_DELAY_REGS];
    logic [31:0] sel_word [monitor_pkg::N_SELECT_REGS];
    for (genvar w = 0; w < monitor_pkg::N_DELAY_REGS; w++) begin : g_dw
        assign dly_word[w] = {delay_r[4*w+3], delay_r[4*w+2],
                              delay_r[4*w+1], delay_r[4*w]};
    end
    for (genvar w = 0; w < monitor_pkg::N_SELECT_REGS; w++) begin : g_sw
        for (genvar j = 0; j < 4; j++) begin : g_f
            if (4*w + j < NO) begin : g_on
                assign sel_word[w][8*j+7:8*j] = {2'b00, select_r[4*w+j]};
            end else begin : g_off
                assign sel_word[w][8*j+7:8*j] = 8'h00;
            end
        end
    end

    // Read mux; unmapped words read as zero
    wire [31:0] rd_val =
        !hi_zero ? 32'h00000000 :
        (a_idx == ctrl_i) ? 32'(ctrl_r) :
        (a_idx == pol_i) ? 32'(polarity_r) :
        (a_idx == elig_i) ? 32'(eligible_r) :
        rd_is_dly ? dly_word[rd_dly[1:0]] :
        rd_is_sel ? sel_word[rd_sel[2:0]] :
        (a_idx == ost_i) ? 32'(out_r) :
        (a_idx == ist_i) ? {delayed_state, raw_state} :
        (a_idx == fo_i) ? 32'(first_r) :
        32'h00000000;

    // Address phase: capture write target, load read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r <= 6'h00;
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
        end else begin
            wr_pend_r <= wr_take;
            wr_idx_r <= a_idx;
            hreadyout_r <= 1'b1;
            if (rd_take) begin
                hrdata_r <= rd_val;
            end
        end
    end

    // ==============================================================
    // Data phase writes
    wire [5:0] wr_dly = wr_idx_r - dly_i;
    wire [5:0] wr_sel = wr_idx_r - sel_i;
    wire w_ctrl = wr_pend_r && (wr_idx_r == ctrl_i);
    wire w_pol = wr_pend_r && (wr_idx_r == pol_i);
    wire w_elig = wr_pend_r && (wr_idx_r == elig_i);
    wire w_dly = wr_pend_r && (wr_idx_r >= dly_i) &&
        (wr_dly < 6'(monitor_pkg::N_DELAY_REGS));
    wire w_sel = wr_pend_r && (wr_idx_r >= sel_i) &&
        (wr_sel < 6'(monitor_pkg::N_SELECT_REGS));

    // Plain configuration words
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= monitor_pkg::CTRL_RST;
            polarity_r <= monitor_pkg::POLARITY_RST;
            eligible_r <= monitor_pkg::ELIGIBLE_RST;
        end else begin
            if (w_ctrl) ctrl_r <= hwdata[monitor_pkg::CTRL_W-1:0];
            if (w_pol) polarity_r <= hwdata[NO-1:0];
            if (w_elig) eligible_r <= hwdata[NI-1:0];
        end
    end

    // Per-input off-delay times, four to a word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NI; i++) delay_r[i] <= monitor_pkg::DELAY_RST;
        end else if (w_dly) begin
            for (int j = 0; j < 4; j++) begin
                delay_r[4*wr_dly[1:0]+j] <= hwdata[8*j+:8];
            end
        end
    end

    // Per-output source codes, four to a word; reset is unused
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NO; i++) select_r[i] <= monitor_pkg::SELECT_RST;
        end else if (w_sel) begin
            for (int j = 0; j < 4; j++) begin
                if (4*wr_sel[2:0] + j < NO) begin
                    select_r[4*wr_sel[2:0]+j] <= hwdata[8*j+:6];
                end
            end
        end
    end

    // ==============================================================
    // Time base: tick every 100 ms, blink toggles each half second
    wire tick_end = (tick_cnt_r == TICK_CYCLES - 24'h000001);
    wire flick_end = (flick_cnt_r == FLICKER_TICKS - 4'h1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 24'h000000;
            tick_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_end ? 24'h000000 : tick_cnt_r + 24'h000001;
            tick_r <= tick_end;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flick_cnt_r <= 4'h0;
            blink_r <= 1'b1;
        end else if (tick_r) begin
            flick_cnt_r <= flick_end ? 4'h0 : flick_cnt_r + 4'h1;
            if (flick_end) blink_r <= ~blink_r;
        end
    end

    // ==============================================================
    // Field inputs
    for (genvar i = 0; i < NI; i++) begin : g_in
        input_conditioner u_cond (
            .hclk(hclk),
            .hresetn(hresetn),
            .pin(field_in[i]),
            .tick(tick_r),
            .delay_ticks(delay_r[i]),
            .raw_state(raw_state[i]),
            .delayed_state(delayed_state[i])
        );
    end

    // ==============================================================
    // First-out capture: only interlock-type inputs may be captured
    wire [NI-1:0] abnormal = eligible_r & ~delayed_state;
    wire [NI-1:0] lowest = abnormal & (~abnormal + 16'h0001);
    wire capture = (first_r == 16'h0000) && (abnormal != 16'h0000);
    // Released only once lockout ends and every interlock is healthy
    wire release_fo = !lockout && (abnormal == 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_r <= 16'h0000;
        end else if (capture) begin
            first_r <= lowest;
        end else if (release_fo) begin
            first_r <= 16'h0000;
        end
    end

    // Flicker blanks the interlocked input in the off half
    wire flick_en = ctrl_r[monitor_pkg::CTRL_FLICKER_BIT];
    wire [NI-1:0] fo_base = lockout ? first_r : ~delayed_state;
    wire [NI-1:0] fo_shown = lockout ? first_r : abnormal;
    wire [NI-1:0] blank = {NI{flick_en && !blink_r}} & fo_shown;
    wire [NI-1:0] first_vec = fo_base & ~blank;

    // ==============================================================
    // Single-bit sources, gated by their enables
    wire relay_en = ctrl_r[monitor_pkg::CTRL_RELAY_EN_BIT];
    wire blower_en = ctrl_r[monitor_pkg::CTRL_BLOWER_EN_BIT];
    wire damper_en = ctrl_r[monitor_pkg::CTRL_DAMPER_EN_BIT];
    wire zone_v = ctrl_r[monitor_pkg::CTRL_ZONE_BIT];
    wire s_permit = zone_v ? burner_permit : zone_permit;
    wire s_relay = relay_en && relay_on;
    wire s_blower = blower_en && blower_on;
    wire s_damper = damper_en && damper_modulating;
    wire s_fire = damper_en && high_fire && !damper_modulating;
    wire s_run = starting_up && !setup_mode;

    wire [10:0] single_vec = {
        s_run,
        diag_two_active,
        diag_one_active,
        s_damper,
        s_fire,
        s_blower,
        s_relay,
        pilot_check_done,
        pilot_off_done,
        s_permit,
        1'b0
    };

    // ==============================================================
    // Output cells
    for (genvar k = 0; k < NO; k++) begin : g_out
        monitor_cell u_cell (
            .code(select_r[k]),
            .reverse(polarity_r[k]),
            .first_vec(first_vec),
            .raw_vec(raw_state),
            .delayed_vec(delayed_state),
            .single_vec(single_vec),
            .drive(drive[k])
        );
    end

    // Registered so the transistors never see a combinational glitch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_r <= 22'h000000;
        end else begin
            out_r <= drive;
        end
    end

    assign transistor_conducting = out_r;
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = 1'b0;
endmodule : monitor_output_select_polarity

// File: src/monitor_pkg.sv
/*
 Constants for the monitor output selector: register map, field layout,
 reset values, source codes and timing counts.
 Assumes a 50 MHz clock and a single AHB-Lite slave port.
*/
// How it works
// - Permit source follows variant's next-module permission
// - Pilot-off source shows pilot off-check done
// - Pilot-check source on only after check completes
// - Relay, blower, fire sources need function enabled
// - Fire source on at high, off otherwise
// - Damper source on while modulation runs
// - Diagnosis sources on during diagnosis, off standby
// - Diagnosis sources ignore polarity, always direct
// - Raw monitors follow live input, no delay
// - Delayed monitors follow input after off-delay
// - Run source on at startup, off in setup
// - Each output own polarity, resets to direct
// - Reverse drives complement of direct value
// - First-out direct is on when input off
// - Capture only for interlock-type input functions
// - Lockout shows only first abnormal input
// - Flicker blinks interlocked input every half second
package monitor_pkg;
    // ==============================================================
    // Sizes
    localparam int N_IN = 16;
    localparam int N_OUT = 22;
    // ==============================================================
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_POLARITY = 8'h04;
    localparam logic [7:0] OFS_ELIGIBLE = 8'h08;
    localparam logic [7:0] OFS_DELAY0 = 8'h0C;
    localparam logic [7:0] OFS_SELECT0 = 8'h1C;
    localparam logic [7:0] OFS_OUT_STATE = 8'h34;
    localparam logic [7:0] OFS_IN_STATE = 8'h38;
    localparam logic [7:0] OFS_FIRST_OUT = 8'h3C;
    localparam int N_DELAY_REGS = 4;
    localparam int N_SELECT_REGS = 6;
    // ==============================================================
    // Control register fields
    localparam int CTRL_FLICKER_BIT = 0;
    localparam int CTRL_RELAY_EN_BIT = 1;
    localparam int CTRL_BLOWER_EN_BIT = 2;
    localparam int CTRL_DAMPER_EN_BIT = 3;
    localparam int CTRL_ZONE_BIT = 4;
    localparam int CTRL_W = 5;
    // ==============================================================
    // Reset values
    localparam logic [4:0] CTRL_RST = 5'h00;
    localparam logic [21:0] POLARITY_RST = 22'h000000;
    localparam logic [15:0] ELIGIBLE_RST = 16'h0000;
    localparam logic [7:0] DELAY_RST = 8'h00;
    localparam logic [5:0] SELECT_RST = 6'h00;
    // ==============================================================
    // Source code: [5:4] group, [3:0] index
    localparam logic [1:0] GRP_SINGLE = 2'h0;
    localparam logic [1:0] GRP_FIRST = 2'h1;
    localparam logic [1:0] GRP_RAW = 2'h2;
    localparam logic [1:0] GRP_DELAYED = 2'h3;
    localparam logic [3:0] SRC_UNUSED = 4'h0;
    localparam logic [3:0] SRC_PERMIT = 4'h1;
    localparam logic [3:0] SRC_PILOT_OFF = 4'h2;
    localparam logic [3:0] SRC_PILOT_CHECK = 4'h3;
    localparam logic [3:0] SRC_RELAY = 4'h4;
    localparam logic [3:0] SRC_BLOWER = 4'h5;
    localparam logic [3:0] SRC_FIRE = 4'h6;
    localparam logic [3:0] SRC_DAMPER = 4'h7;
    localparam logic [3:0] SRC_DIAG_ONE = 4'h8;
    localparam logic [3:0] SRC_DIAG_TWO = 4'h9;
    localparam logic [3:0] SRC_RUN = 4'hA;
    localparam int N_SINGLE = 11;
    // ==============================================================
    // Timing
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 100;
    localparam logic [23:0] TICK_CYCLES = 24'(CLK_HZ / 1000 * TICK_MS);
    localparam int FLICKER_MS = 500;
    localparam logic [3:0] FLICKER_TICKS = 4'(FLICKER_MS / TICK_MS);
endpackage : monitor_pkg
